/* src/split_xfer_pkg.sv */
/*
  Constants shared by the split transfer controller: command encodings,
  pin widths and power-up timing counts.
  Assumes a single 100 MHz clock and a multiport DRAM on the far side
  whose strobes are driven directly by the controller.
*/
// Notes on behaviour
// RL1: Device splits serial buffer into two halves.
// RL2: Device makes column msb half select internally.
// RL3: Device shows active half on indicator.
// RL4: Indicator toggles after last shift of half.
// RL5: Split read copies 256 words into idle half.
// RL6: Active half keeps shifting during split read.
// RL7: Strobes need no alignment to shift clock.
// RL8: Wait setup delay after indicator toggle.
// RL9: Full read transfer precedes any split read.
// RL10: Split write copies idle half into row.
// RL11: Write mask on data pins at row strobe.
// RL12: Masked write transfer precedes any split write.
// RL13: Hold strobes high 200 us after power-up.
// RL14: Eight dummy row and shift cycles next.
// RL15: Transfer output enable high during initialization.
// RL16: Refresh counter uses eight column-before-row cycles.
// RL17: Set initial state after initialization.
// RL18: Special function select chooses split transfer.
// RL19: Split transfers keep serial direction.
// RL20: Taps exclude last location of each half.
// RL21: Row msb partitions RAM and serial buffer.
package split_xfer_pkg;

  // Clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 10000;

  // Power-up pause, microseconds, and its count in cycles (rounded up).
  localparam int POWERUP_US     = 200;
  localparam int POWERUP_CYCLES =
    (POWERUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Split transfer setup delay in nanoseconds and cycles (rounded up).
  localparam int SETUP_DELAY_NS     = 20;
  localparam int SETUP_DELAY_CYCLES =
    (SETUP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Strobe phase widths in cycles.
  localparam int STROBE_PHASE_CYCLES = 6;

  // Dummy cycles needed during initialization.
  localparam int DUMMY_CYCLES = 8;

  // Width of the random data pins and the multiplexed address pins.
  localparam int DATA_W = 16;
  localparam int ADDR_W = 9;

  // Highest legal tap inside one buffer half.
  localparam logic [7:0] TAP_MAX = 8'hfe;

  // Transfer kinds requested by the user side.
  typedef enum logic [1:0] {
    XFER_READ        = 2'h0,
    XFER_MASKED_WR   = 2'h1,
    XFER_SPLIT_READ  = 2'h2,
    XFER_SPLIT_WRITE = 2'h3
  } xfer_kind_t;

endpackage

/* src/cycle_timer.sv */
/*
  Down counter that reports when a loaded count has run out.
  Assumes the loader holds the count stable during the load pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  expired
);

  logic [WIDTH-1:0] remaining;

  // =====================================================================
  // Counter
  // Load wins over counting; expiry is a level while the count is zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= count;
    end else if (remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end

  // Expiry looks at the count only, so logic that loads on expiry
  // forms no combinational loop through this port.
  assign expired = (remaining == '0);

endmodule
`default_nettype wire

/* src/split_xfer_ctrl.sv */
/*
  Host controller for a dual-port video DRAM with split serial transfer.
  It runs the power-up sequence, then issues read, masked write, split
  read and split write transfer cycles on request, keeping the order
  and setup delays that the memory needs.
  Assumes the memory's active half indicator is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module split_xfer_ctrl
  import split_xfer_pkg::*;
#(
  parameter int POWERUP_WAIT = split_xfer_pkg::POWERUP_CYCLES,
  parameter bit USE_CBR      = 1'b0
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire split_xfer_pkg::xfer_kind_t reqKind,
  input  wire logic [8:0]                reqRow,
  input  wire logic [7:0]                reqTap,
  input  wire logic [15:0]               reqMask,
  output logic                           initDone,
  output logic                           orderError,
  output logic                           rowStrobe_n,
  output logic                           colStrobe_n,
  output logic                           transferOutputEnable_n,
  output logic                           writeEnableLower_n,
  output logic                           writeEnableUpper_n,
  output logic                           specialFunctionSelect,
  output logic [8:0]                     address,
  output logic                           serialShiftClock,
  output logic [15:0]                    ramDataOut,
  output logic                           ramDataOe_n,
  input  wire logic                      activeHalfIndicator
);
  import split_xfer_pkg::*;

  typedef enum logic [2:0] {
    ST_PAUSE = 3'b000,
    ST_DUMMY = 3'b001,
    ST_IDLE  = 3'b011,
    ST_ROW   = 3'b010,
    ST_COL   = 3'b110,
    ST_DONE  = 3'b111
  } state_t;

  state_t     state;
  state_t     next_state;
  logic [3:0] dummyCount;
  logic       phaseHigh;
  logic       seenRead;
  logic       seenMaskedWr;
  logic       halfSync1;
  logic       halfSync2;
  logic       halfPrev;
  logic       timerLoad;
  logic [31:0] timerCount;
  logic       timerExpired;
  xfer_kind_t kindHeld;
  logic [7:0] tapHeld;
  logic       pauseArmed;
  logic       startPause;

  // =====================================================================
  // Indicator synchroniser and toggle detect
  // The first stage feeds only the second one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halfSync1 <= 1'b0;
      halfSync2 <= 1'b0;
      halfPrev  <= 1'b0;
    end else begin
      halfSync1 <= activeHalfIndicator;
      halfSync2 <= halfSync1;
      halfPrev  <= halfSync2;
    end
  end

  // A toggle of the indicator seen in ST_IDLE restarts the setup delay.
  wire halfToggled = halfSync2 ^ halfPrev;

  // =====================================================================
  // Request decode
  wire isSplit  = (reqKind == XFER_SPLIT_READ) ||
                  (reqKind == XFER_SPLIT_WRITE);
  wire orderOk  = (reqKind == XFER_SPLIT_READ)  ? seenRead :      // RL9
                  (reqKind == XFER_SPLIT_WRITE) ? seenMaskedWr :  // RL12
                  1'b1;
  wire tapOk    = reqTap <= TAP_MAX;                              // RL20
  wire canStart = (state == ST_IDLE) && timerExpired &&
                  !halfToggled;                                   // RL8
  wire accept   = reqValid && canStart && orderOk && tapOk;
  wire isWrite  = (reqKind == XFER_MASKED_WR) ||
                  (reqKind == XFER_SPLIT_WRITE);
  wire phaseEnd = timerExpired && (state != ST_IDLE);

  assign reqReady = canStart && orderOk && tapOk;
  assign initDone = (state != ST_PAUSE) && (state != ST_DUMMY);

  // One pulse after reset release starts the power-up pause.
  assign startPause = !pauseArmed;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pauseArmed <= 1'b0;
    else         pauseArmed <= 1'b1;
  end

  // Timer loads: pause at reset release, strobe phases, setup delay.
  // The end of the pause loads a full phase so the first dummy cycle
  // is as long as the others.
  always_comb begin
    timerLoad  = 1'b0;
    timerCount = 32'(STROBE_PHASE_CYCLES);
    if (halfToggled && state == ST_IDLE) begin
      timerLoad  = 1'b1;
      timerCount = 32'(SETUP_DELAY_CYCLES);                       // RL8
    end else if (accept || (phaseEnd && pauseArmed)) begin
      timerLoad  = 1'b1;
    end
  end

  cycle_timer #(.WIDTH(32)) u_timer (
    .clk     (clk),
    .arst_n  (arst_n),
    .load    (timerLoad || startPause),
    .count   (startPause ? 32'(POWERUP_WAIT) : timerCount),       // RL13
    .expired (timerExpired)
  );

  // =====================================================================
  // State sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_PAUSE: if (pauseArmed && timerExpired) next_state = ST_DUMMY;
      ST_DUMMY: if (phaseEnd && phaseHigh &&
                    dummyCount == 4'(DUMMY_CYCLES - 1)) begin     // RL14
                  next_state = ST_IDLE;
                end
      ST_IDLE:  if (accept) next_state = ST_ROW;
      ST_ROW:   if (phaseEnd) next_state = ST_COL;
      ST_COL:   if (phaseEnd) next_state = ST_DONE;
      ST_DONE:  if (phaseEnd) next_state = ST_IDLE;
      default:  next_state = ST_PAUSE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state <= ST_PAUSE;
    else         state <= next_state;
  end

  // Dummy cycle counter and phase; low then high makes one cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dummyCount <= 4'h0;
      phaseHigh  <= 1'b0;
    end else if (state == ST_DUMMY && phaseEnd) begin
      phaseHigh <= !phaseHigh;
      if (phaseHigh) dummyCount <= dummyCount + 4'h1;
    end
  end

  // Order bookkeeping: split reads need a prior full read, split writes
  // a prior masked write. A new conventional transfer clears the other kind's flag.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seenRead     <= 1'b0;
      seenMaskedWr <= 1'b0;
      orderError   <= 1'b0;
      kindHeld     <= XFER_READ;
    end else begin
      orderError <= reqValid && canStart && !(orderOk && tapOk);
      if (accept) begin                                           // RL17
        kindHeld <= reqKind;
        if (reqKind == XFER_READ) begin                           // RL9
          seenRead     <= 1'b1;
          seenMaskedWr <= 1'b0;
        end else if (reqKind == XFER_MASKED_WR) begin             // RL12
          seenMaskedWr <= 1'b1;
          seenRead     <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // Pin drive
  // Strobes start high and stay high through the pause (RL13, RL15).
  wire inXfer  = (state == ST_ROW) || (state == ST_COL);
  wire dumLow  = (state == ST_DUMMY) && !phaseHigh;
  wire heldWr  = (kindHeld == XFER_MASKED_WR) ||
                 (kindHeld == XFER_SPLIT_WRITE);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rowStrobe_n            <= 1'b1;
      colStrobe_n            <= 1'b1;
      transferOutputEnable_n <= 1'b1;
      writeEnableLower_n     <= 1'b1;
      writeEnableUpper_n     <= 1'b1;
      specialFunctionSelect  <= 1'b0;
      address                <= 9'h000;
      serialShiftClock       <= 1'b0;
      ramDataOut             <= 16'h0000;
      ramDataOe_n            <= 1'b1;
      tapHeld                <= 8'h00;
    end else begin
      // Refresh style dummy cycles drop the column strobe one cycle
      // ahead of the row strobe; plain ones use the row strobe alone.
      rowStrobe_n <= !(inXfer ||
                       (dumLow && (!USE_CBR || !colStrobe_n)));   // RL7
      colStrobe_n <= !((state == ST_COL) || (USE_CBR && dumLow)); // RL16
      serialShiftClock <= (state == ST_DUMMY) && phaseHigh;       // RL14
      // Transfer enable falls with the request, so it is set up one
      // cycle before the row strobe falls.
      transferOutputEnable_n <= !(inXfer || accept);              // RL15
      if (accept) begin
        tapHeld               <= reqTap;
        specialFunctionSelect <= isSplit;                         // RL18
        address               <= reqRow;                          // RL21
        writeEnableLower_n    <= !isWrite;
        writeEnableUpper_n    <= !isWrite;
        ramDataOut <= (reqKind == XFER_MASKED_WR) ? 16'h0000
                                                  : reqMask;      // RL11
        ramDataOe_n <= !isWrite;
      end else if (state == ST_ROW && phaseEnd) begin
        address     <= {1'b0, tapHeld};  // Half bit comes from device.
        ramDataOe_n <= 1'b1;
      end else if (state == ST_DONE && phaseEnd) begin
        writeEnableLower_n    <= 1'b1;
        writeEnableUpper_n    <= 1'b1;
        specialFunctionSelect <= 1'b0;
        ramDataOe_n           <= 1'b1;
      end
      if (heldWr && state == ST_COL) ramDataOe_n <= 1'b1;
    end
  end

  // =====================================================================
  // Checks
  a_trg_high_init: assert property (@(posedge clk)  // RL15
    disable iff (!arst_n) !initDone |-> transferOutputEnable_n)
    else $error("Transfer enable low during initialization.");

  a_pause_no_ras: assert property (@(posedge clk)  // RL13
    disable iff (!arst_n) state == ST_PAUSE |-> rowStrobe_n)
    else $error("Row strobe active during power-up pause.");

  a_split_rd_order: assert property (@(posedge clk)  // RL9
    disable iff (!arst_n)
    accept && reqKind == XFER_SPLIT_READ |-> seenRead)
    else $error("Split read issued without prior read transfer.");

  a_split_wr_order: assert property (@(posedge clk)  // RL12
    disable iff (!arst_n)
    accept && reqKind == XFER_SPLIT_WRITE |-> seenMaskedWr)
    else $error("Split write issued without prior masked write.");

  a_setup_after_toggle: assert property (@(posedge clk)  // RL8
    disable iff (!arst_n)
    halfToggled && state == ST_IDLE |=> !reqReady)
    else $error("Transfer allowed before setup delay elapsed.");

  a_dsf_split: assert property (@(posedge clk)  // RL18
    disable iff (!arst_n) accept |=> specialFunctionSelect == $past(isSplit))
    else $error("Special function select does not match request.");

  a_trg_before_ras: assert property (@(posedge clk)  // RL18
    disable iff (!arst_n)
    $fell(rowStrobe_n) && state != ST_DUMMY |->
      !$past(transferOutputEnable_n))
    else $error("Row strobe fell without transfer enable set up.");

  a_cbr_dummy: assert property (@(posedge clk)  // RL16
    disable iff (!arst_n)
    USE_CBR && $fell(rowStrobe_n) && state == ST_DUMMY |-> !colStrobe_n)
    else $error("Refresh dummy cycle lacks an early column strobe.");

endmodule
`default_nettype wire

/* tb/dram_model.sv */
/*
  Behavioural model of the video DRAM random port and its active half flag.
  Assumes one controller drives all strobes; lastShift marks the final
  serial shift of the active half.
*/
`timescale 1ns/10ps
`default_nettype none
module dram_model (
  input  wire logic        rowStrobe_n,
  input  wire logic        transferOutputEnable_n,
  input  wire logic        writeEnableLower_n,
  input  wire logic        writeEnableUpper_n,
  input  wire logic        specialFunctionSelect,
  input  wire logic [8:0]  address,
  input  wire logic        serialShiftClock,
  input  wire logic [15:0] ramDataOut,
  input  wire logic        ramDataOe_n,
  input  wire logic        lastShift,
  output logic             activeHalfIndicator,
  output var int           rowCycles,
  output var int           shiftCycles,
  output var int           xferCount,
  output logic [1:0]       lastKind,
  output logic [15:0]      lastMask,
  output logic             serialIn,
  output logic             lastRowMsb
);
  // ======================================================================
  // Power-up state
  // Counters start empty and the first half is the active one.
  initial begin
    activeHalfIndicator = 1'b0;
    rowCycles = 0;
    shiftCycles = 0;
    xferCount = 0;
    serialIn = 1'b0;
  end

  // Each row strobe fall with transfer enable low latches the transfer kind, row half and mask.
  always @(negedge rowStrobe_n) begin
    rowCycles++;
    if (transferOutputEnable_n === 1'b0) begin
      xferCount++;
      lastKind <= {specialFunctionSelect,
                   ~(writeEnableLower_n & writeEnableUpper_n)};
      lastRowMsb <= address[8];
      lastMask <= ramDataOe_n ? 16'hxxxx : ramDataOut;
      // Only conventional transfers set the serial port direction.
      if (!specialFunctionSelect)
        serialIn <= ~(writeEnableLower_n & writeEnableUpper_n);
    end
  end

  // Dummy and data shift edges are counted.
  always @(posedge serialShiftClock) begin
    shiftCycles++;
  end

  // The flag flips once the last shift of the active half has occurred.
  always @(posedge lastShift) begin
    activeHalfIndicator <= ~activeHalfIndicator;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking testbench for the split transfer controller.
  Assumes dram_model stands in for the memory on the far side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import split_xfer_pkg::*;
  localparam int WAIT = 50;
  logic clk, arst_n, reqValid, reqReady, initDone, orderError, lastShift;
  logic rowStrobe_n, colStrobe_n, toe_n, wel_n, weu_n, special_function_select, sclk, oe_n;
  logic activeHalfIndicator, lastRowMsb, serialIn, cbrRow_n, cbrCol_n;
  logic cbrInitDone;
  int cbrCycles;
  xfer_kind_t reqKind;
  logic [8:0] reqRow, address;
  logic [7:0] reqTap;
  logic [15:0] reqMask, ramDataOut, lastMask;
  logic [1:0] lastKind;
  int rowCycles, shiftCycles, xferCount, errors, compares, cycles, relCycles;
  bit toeBad, rasBad;

  // ======================================================================
  // Clock, design, model and watchdog
  initial clk = 1'b0;
  always #5 clk = ~clk;

  split_xfer_ctrl #(.POWERUP_WAIT(WAIT), .USE_CBR(1'b0)) uut (
    .clk(clk), .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady),
    .reqKind(reqKind), .reqRow(reqRow), .reqTap(reqTap), .reqMask(reqMask),
    .initDone(initDone), .orderError(orderError), .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n), .transferOutputEnable_n(toe_n),
    .writeEnableLower_n(wel_n), .writeEnableUpper_n(weu_n),
    .specialFunctionSelect(special_function_select), .address(address),
    .serialShiftClock(sclk), .ramDataOut(ramDataOut), .ramDataOe_n(oe_n),
    .activeHalfIndicator(activeHalfIndicator));

  dram_model mem (
    .rowStrobe_n(rowStrobe_n), .transferOutputEnable_n(toe_n),
    .writeEnableLower_n(wel_n), .writeEnableUpper_n(weu_n),
    .specialFunctionSelect(special_function_select), .address(address),
    .serialShiftClock(sclk), .ramDataOut(ramDataOut), .ramDataOe_n(oe_n),
    .lastShift(lastShift), .activeHalfIndicator(activeHalfIndicator),
    .rowCycles(rowCycles), .shiftCycles(shiftCycles),
    .xferCount(xferCount), .lastKind(lastKind), .lastMask(lastMask),
    .lastRowMsb(lastRowMsb), .serialIn(serialIn));

  // Second controller in refresh style dummy mode, watched during init.
  split_xfer_ctrl #(.POWERUP_WAIT(WAIT), .USE_CBR(1'b1)) uutCbr (
    .clk(clk), .arst_n(arst_n), .reqValid(reqValid), .reqReady(),
    .reqKind(reqKind), .reqRow(reqRow), .reqTap(reqTap), .reqMask(reqMask),
    .initDone(cbrInitDone), .orderError(), .rowStrobe_n(cbrRow_n),
    .colStrobe_n(cbrCol_n), .transferOutputEnable_n(),
    .writeEnableLower_n(), .writeEnableUpper_n(),
    .specialFunctionSelect(), .address(), .serialShiftClock(),
    .ramDataOut(), .ramDataOe_n(),
    .activeHalfIndicator(activeHalfIndicator));

  // Counts row strobe falls that find the column strobe already low.
  always @(negedge cbrRow_n) begin
    if (cbrCol_n === 1'b0) cbrCycles++;
  end

  // Watches the pause and initialization levels and cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (arst_n === 1'b1) relCycles++;
    if (arst_n === 1'b1 && initDone !== 1'b1 && toe_n !== 1'b1) toeBad = 1;
    if (arst_n === 1'b1 && relCycles < WAIT && rowStrobe_n !== 1'b1)
      rasBad = 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ======================================================================
  // Shared tasks
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Presents one request and holds it until the accepting edge.
  task automatic send(input xfer_kind_t k, input logic [7:0] tap,
                      output int waited);
    @(posedge clk);
    reqKind <= k;
    reqTap <= tap;
    reqValid <= 1'b1;
    waited = 0;
    do begin
      @(negedge clk);
      waited++;
    end while (reqReady !== 1'b1 && waited < 200);
    @(posedge clk);
    reqValid <= 1'b0;
    check(waited < 200, "request never accepted");
    repeat (25) @(posedge clk);
  endtask

  // Presents a request that must be refused with an order error pulse.
  task automatic refuse(input xfer_kind_t k, input logic [7:0] tap);
    bit seen;
    bit rdy;
    seen = 0;
    rdy = 0;
    @(posedge clk);
    reqKind <= k;
    reqTap <= tap;
    reqValid <= 1'b1;
    repeat (12) begin
      @(negedge clk);
      seen |= (orderError === 1'b1);
      rdy |= (reqReady === 1'b1);
    end
    @(posedge clk);
    reqValid <= 1'b0;
    check(seen && !rdy, "illegal request was not refused");
  endtask

  // ======================================================================
  // Scenarios
  task automatic t_init();
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(n < 1000, "initialization never finished");
    check(!rasBad, "row strobe active during pause");
    check(rowCycles >= 8, "too few dummy row cycles");
    check(shiftCycles >= 8, "too few dummy shift cycles");
    check(!toeBad && xferCount == 0, "transfer enable low in init");
    check(cbrInitDone === 1'b1 && cbrCycles >= 8,
          "too few refresh style dummy cycles");
  endtask

  task automatic t_order();
    refuse(XFER_SPLIT_READ, 8'h00);
    refuse(XFER_SPLIT_WRITE, 8'h00);
  endtask

  // Read, split read, masked write and split write at the top legal tap,
  // then a split write one tap beyond it.
  task automatic t_kinds();
    xfer_kind_t k;
    int w;
    for (int i = 0; i < 4; i++) begin
      k = xfer_kind_t'({i[0], i[1]});
      send(k, 8'hfe, w);
      check(lastKind === 2'(k), "wrong transfer kind decoded");
      check(lastRowMsb === 1'b1, "wrong row half");
      check(serialIn === (i >= 2), "wrong serial direction");
      if (k == XFER_MASKED_WR)
        check(lastMask === 16'h0000, "masked write mask");
      if (k == XFER_SPLIT_WRITE)
        check(lastMask === 16'h5a3c, "split write mask");
    end
    refuse(XFER_SPLIT_WRITE, 8'hff);
  endtask

  // A request right after a half switch waits out the setup delay.
  task automatic t_setup();
    int w;
    @(posedge clk);
    lastShift <= 1'b1;
    @(posedge clk);
    lastShift <= 1'b0;
    send(XFER_SPLIT_WRITE, 8'h10, w);
    check(w > SETUP_DELAY_CYCLES, "split write inside setup delay");
  endtask

  // ======================================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    reqValid = 1'b0;
    lastShift = 1'b0;
    reqKind = XFER_READ;
    reqRow = 9'h1a5;
    reqTap = 8'h00;
    reqMask = 16'h5a3c;
    errors = 0;
    compares = 0;
    cycles = 0;
    relCycles = 0;
    cbrCycles = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_init();
    t_order();
    t_kinds();
    t_setup();
    print_verdict();
  end
endmodule
`default_nettype wire
